/* shared/crtac_pkg.sv */
// Constants shared by the attribute and cursor logic of the CRT controller.
// Assumes a single character clock and a 32-bit classic Wishbone bus.
`default_nettype none
package crtac_pkg;

   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_FILL   = 8'h04;
   localparam logic [7:0] OFF_CURSOR = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam int CTL_SHOW_HIDDEN = 0;
   localparam int CTL_NARROW      = 1;
   localparam int CTL_FILL_ATTR   = 2;
   localparam int CTL_ABS_EN      = 3;
   localparam int CTL_ABS_SHAPE   = 4;
   localparam int CTL_ATT_SHAPE   = 6;
   localparam int CTL_SKEW        = 8;
   localparam int CTL_HBLANK      = 16;
   localparam int CUR_X_POS       = 0;
   localparam int CUR_Y_POS       = 16;
   localparam logic [31:0] CTRL_RST   = 32'h0020_0000;
   localparam logic [31:0] FILL_RST   = 32'h0000_0020;
   localparam logic [31:0] CURSOR_RST = 32'h0000_0000;

   // ****************************************************************
   // Attribute word and row buffer
   // ****************************************************************
   localparam int ATTR_LATCH  = 15;
   localparam int ATTR_CURSOR = 14;
   localparam int ATTR_IGNORE = 13;
   localparam int AP_REVERSE  = 5;
   localparam int AP_UNDERLN  = 1;
   localparam logic [15:0] ATTR_RST  = 16'h0000;
   localparam logic [9:0]  ROWA_RST  = 10'h000;
   localparam logic [7:0]  CAP_WIDE  = 8'h84;
   localparam logic [7:0]  CAP_NARROW = 8'h60;

   // ****************************************************************
   // Row attribute timing in character clocks
   // ****************************************************************
   localparam logic [8:0] ROW_ON_CLKS  = 9'h007;
   localparam logic [8:0] ROW_OFF_LEAD = 9'h001;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      SHP_WHOLE = 2'h0,
      SHP_PART  = 2'h1,
      SHP_REV   = 2'h2,
      SHP_UNDER = 2'h3
   } crtac_shape_t;

   typedef enum logic [1:0] {
      ST_LOAD = 2'h0,
      ST_FILL = 2'h1,
      ST_DONE = 2'h3
   } crtac_state_t;

endpackage : crtac_pkg
`default_nettype wire

/* rtl/crtac_cursor_shape.sv */
// Cursor shape decoder: turns one cursor hit into pin contributions.
// Assumes hit, scan line and limits are sampled in the same clock.
`timescale 1ns/1ps
`default_nettype none
module crtac_cursor_shape (
   input  wire logic [1:0] shape,
   input  wire logic       hit,
   input  wire logic [4:0] scan_line,
   input  wire logic [4:0] start_line,
   input  wire logic [4:0] end_line,
   output logic            cur,
   output logic            rev,
   output logic            ul
);
   logic in_band;

   // Band check and steering of the hit to one of three pins.
   always_comb begin
      in_band = (scan_line >= start_line) && (scan_line <= end_line);
      cur     = 1'b0;
      rev     = 1'b0;
      ul      = 1'b0;
      case (shape)
         crtac_pkg::SHP_WHOLE: cur = hit;
         crtac_pkg::SHP_PART:  cur = hit & in_band;
         crtac_pkg::SHP_REV:   rev = hit & in_band;
         crtac_pkg::SHP_UNDER: ul  = hit & in_band;
         default:              cur = 1'b0;
      endcase
   end
endmodule : crtac_cursor_shape
`default_nettype wire

/* rtl/crtac_top.sv */
// Attribute, row attribute, cursor and fill logic of a CRT controller.
// Assumes the character clock is clk_sys and all inputs are synchronous.
// Function
// - Attribute-less characters take the default attribute.
// - Latched attribute reloads the default attribute.
// - Latched attribute persists across rows and regions.
// - Ignored character and attribute are not loaded.
// - Latched ignore skips until latched non-ignore.
// - Row attribute on pins 0-4, 6-10.
// - Row attribute register updates per redefinition block.
// - Row attribute: seven clocks in, one early out.
// - Absolute cursor fetched at vertical retrace.
// - Scrolling cursor moves only at relink.
// - Absolute cursor hit steered by mask bits.
// - Cursor enable clear suppresses absolute cursor.
// - Attribute cursor on cursor-bit characters, own mask.
// - Both cursors share start and end lines.
// - Four shapes: whole, part, reverse, underline.
// - Unused row buffer filled with fill code.
// - Fill invokes no attribute when disabled.
// - One fill attribute word when enabled.
// - Fill characters ignore the ignore bit.
// - Bits 15 latch, 14 cursor, 13 ignore.
// - Show hidden loads ignored characters anyway.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module crtac_top (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        row_start,
   input  wire logic        ld_valid,
   input  wire logic [7:0]  ld_char,
   input  wire logic        ld_has_attr,
   input  wire logic [15:0] ld_attr,
   output logic             ld_ready,
   input  wire logic        seg_last,
   input  wire logic [15:0] fill_attr,
   output logic             buf_we,
   output logic      [7:0]  buf_addr,
   output logic      [7:0]  buf_char,
   output logic      [15:0] buf_attr,
   input  wire logic        rrb_valid,
   input  wire logic [9:0]  rrb_row_attr,
   input  wire logic [4:0]  rrb_cursor_start_line_start,
   input  wire logic [4:0]  rrb_cursor_start_line_end,
   input  wire logic        blank,
   input  wire logic        vretrace,
   input  wire logic        scroll_active,
   input  wire logic        relink,
   input  wire logic        disp_valid,
   input  wire logic [15:0] disp_attr,
   input  wire logic [7:0]  disp_col,
   input  wire logic [6:0]  disp_row,
   input  wire logic [4:0]  scan_line,
   output logic      [10:0] attr_port_pin,
   output logic             cursor_pin
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic                   rst_s1_reg;
   logic                   rst_n;
   logic [31:0]            ctrl_reg;
   logic [31:0]            fill_reg;
   logic [31:0]            cursor_reg;
   logic [15:0]            default_reg;
   logic                   ignore_reg;
   logic [9:0]             row_attr_reg;
   logic [4:0]             cursor_start_line_start_reg;
   logic [4:0]             cursor_start_line_end_reg;
   logic [7:0]             cur_x_reg;
   logic [6:0]             cur_y_reg;
   logic                   vret_d_reg;
   logic                   blank_d_reg;
   logic [7:0]             hb_cnt_reg;
   logic                   row_on_reg;
   logic                   row_on_next;
   crtac_pkg::crtac_state_t state_reg;
   crtac_pkg::crtac_state_t state_next;
   logic [7:0]             ptr_reg;
   logic                   fill_first_reg;
   logic [7:0]             cap;
   logic                   take;
   logic                   skip;
   logic [15:0]            fill_word;
   logic                   show_hidden;
   logic                   skew;
   logic                   abs_hit;
   logic                   att_hit;
   logic                   a_cur, a_rev, a_ul;
   logic                   t_cur, t_rev, t_ul;
   logic [10:0]            ap_now;
   logic [10:0]            ap_d1_reg;
   logic                   wb_req;
   logic [31:0]            rd_data;
   logic [8:0]             hb_nxt;

   // Byte-lane merge for register writes.
   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : wmerge

   // ****************************************************************
   // Reset release
   // ****************************************************************
   // Two-stage release so every flop leaves reset on the same edge.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   assign wb_req      = wb_cyc_i & wb_stb_i;
   assign show_hidden = ctrl_reg[crtac_pkg::CTL_SHOW_HIDDEN];
   assign skew        = ctrl_reg[crtac_pkg::CTL_SKEW];

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      case (wb_adr_i)
         crtac_pkg::OFF_CTRL:   rd_data = ctrl_reg;
         crtac_pkg::OFF_FILL:   rd_data = fill_reg;
         crtac_pkg::OFF_CURSOR: rd_data = cursor_reg;
         crtac_pkg::OFF_STATUS:
            rd_data = {4'h0, row_attr_reg, 1'b0, ignore_reg, default_reg};
         default:               rd_data = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after the request; it drops in the following cycle.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= rd_data;
      end
   end

   // Writes take effect on the edge where the master sees ack.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg   <= crtac_pkg::CTRL_RST;
         fill_reg   <= crtac_pkg::FILL_RST;
         cursor_reg <= crtac_pkg::CURSOR_RST;
      end else if (wb_req && wb_we_i && wb_ack_o) begin
         case (wb_adr_i)
            crtac_pkg::OFF_CTRL:
               ctrl_reg <= wmerge(ctrl_reg, wb_dat_i, wb_sel_i);
            crtac_pkg::OFF_FILL:
               fill_reg <= wmerge(fill_reg, wb_dat_i, wb_sel_i);
            crtac_pkg::OFF_CURSOR:
               cursor_reg <= wmerge(cursor_reg, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Row buffer loading and fill
   // ****************************************************************
   assign cap  = ctrl_reg[crtac_pkg::CTL_NARROW] ? crtac_pkg::CAP_NARROW
                                                 : crtac_pkg::CAP_WIDE;
   assign take = ld_valid & ld_ready;

   // A character is dropped while ignore is in force and not shown.
   always_comb begin
      if (ld_has_attr) begin
         skip = ~show_hidden & (ld_attr[crtac_pkg::ATTR_IGNORE] |
                (ignore_reg & ~ld_attr[crtac_pkg::ATTR_LATCH]));
      end else begin
         skip = ~show_hidden & ignore_reg;
      end
   end

   // Fill word: one fetched attribute, ignore bit discarded.
   always_comb begin
      fill_word = fill_attr;
      fill_word[crtac_pkg::ATTR_IGNORE] = 1'b0;
   end

   // Load, fill and done sequencing per row.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         crtac_pkg::ST_LOAD: begin
            if (seg_last) begin
               state_next = (ptr_reg < cap) ? crtac_pkg::ST_FILL
                                            : crtac_pkg::ST_DONE;
            end
         end
         crtac_pkg::ST_FILL: begin
            if (ptr_reg >= cap - 8'h01) begin
               state_next = crtac_pkg::ST_DONE;
            end
         end
         crtac_pkg::ST_DONE: state_next = crtac_pkg::ST_DONE;
         default:            state_next = crtac_pkg::ST_DONE;
      endcase
      if (row_start) begin
         state_next = crtac_pkg::ST_LOAD;
      end
   end

   // State, pointer and buffer write port.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= crtac_pkg::ST_DONE;
         ptr_reg        <= 8'h00;
         fill_first_reg <= 1'b0;
         ld_ready       <= 1'b0;
         buf_we         <= 1'b0;
         buf_addr       <= 8'h00;
         buf_char       <= 8'h00;
         buf_attr       <= 16'h0000;
      end else begin
         state_reg <= state_next;
         ld_ready  <= (state_next == crtac_pkg::ST_LOAD);
         buf_we    <= 1'b0;
         if (row_start) begin
            ptr_reg <= 8'h00;
         end else if (state_reg == crtac_pkg::ST_LOAD) begin
            fill_first_reg <= 1'b1;
            if (take && !skip && ptr_reg < cap) begin
               buf_we   <= 1'b1;
               buf_addr <= ptr_reg;
               buf_char <= ld_char;
               buf_attr <= ld_has_attr ? ld_attr : default_reg;
               ptr_reg  <= ptr_reg + 8'h01;
            end
         end else if (state_reg == crtac_pkg::ST_FILL) begin
            fill_first_reg <= 1'b0;
            buf_we   <= 1'b1;
            buf_addr <= ptr_reg;
            buf_char <= fill_reg[7:0];
            ptr_reg  <= ptr_reg + 8'h01;
            if (ctrl_reg[crtac_pkg::CTL_FILL_ATTR] && fill_first_reg) begin
               buf_attr <= fill_word;
            end else begin
               buf_attr <= default_reg;
            end
         end
      end
   end

   // Default attribute and latched ignore; kept across rows and regions.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         default_reg <= crtac_pkg::ATTR_RST;
         ignore_reg  <= 1'b0;
      end else if (state_reg == crtac_pkg::ST_LOAD && take && ld_has_attr
                   && ld_attr[crtac_pkg::ATTR_LATCH]) begin
         default_reg <= ld_attr;
         ignore_reg  <= ld_attr[crtac_pkg::ATTR_IGNORE];
      end else if (state_reg == crtac_pkg::ST_FILL && fill_first_reg &&
                   ctrl_reg[crtac_pkg::CTL_FILL_ATTR] &&
                   fill_attr[crtac_pkg::ATTR_LATCH]) begin
         default_reg <= fill_word;
      end
   end

   // ****************************************************************
   // Row attribute
   // ****************************************************************
   // Capture of row attribute and cursor limits from each block.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         row_attr_reg   <= crtac_pkg::ROWA_RST;
         cursor_start_line_start_reg <= 5'h00;
         cursor_start_line_end_reg   <= 5'h00;
      end else if (rrb_valid) begin
         row_attr_reg   <= rrb_row_attr;
         cursor_start_line_start_reg <= rrb_cursor_start_line_start;
         cursor_start_line_end_reg   <= rrb_cursor_start_line_end;
      end
   end

   // Window inside blanking, shifted by the programmed skew.
   always_comb begin
      hb_nxt = {1'b0, hb_cnt_reg} + 9'h001;
      row_on_next = blank &&
         (hb_nxt >= crtac_pkg::ROW_ON_CLKS + {8'h00, skew}) &&
         (hb_nxt < {1'b0, ctrl_reg[crtac_pkg::CTL_HBLANK +: 8]} -
                   crtac_pkg::ROW_OFF_LEAD + {8'h00, skew});
   end

   // Blanking cycle counter and row attribute window flag.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         blank_d_reg <= 1'b0;
         hb_cnt_reg  <= 8'h00;
         row_on_reg  <= 1'b0;
      end else begin
         blank_d_reg <= blank;
         row_on_reg  <= row_on_next;
         if (blank && !blank_d_reg) begin
            hb_cnt_reg <= 8'h01;
         end else if (blank && hb_cnt_reg != 8'hFF) begin
            hb_cnt_reg <= hb_cnt_reg + 8'h01;
         end else if (!blank) begin
            hb_cnt_reg <= 8'h00;
         end
      end
   end

   // ****************************************************************
   // Cursors
   // ****************************************************************
   // Active position: fetched at retrace when not scrolling, and at every relink.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vret_d_reg <= 1'b0;
         cur_x_reg  <= 8'h00;
         cur_y_reg  <= 7'h00;
      end else begin
         vret_d_reg <= vretrace;
         if ((vretrace && !vret_d_reg && !scroll_active) || relink) begin
            cur_x_reg <= cursor_reg[crtac_pkg::CUR_X_POS +: 8];
            cur_y_reg <= cursor_reg[crtac_pkg::CUR_Y_POS +: 7];
         end
      end
   end

   // Beam matches for both cursor kinds.
   assign abs_hit = disp_valid & ctrl_reg[crtac_pkg::CTL_ABS_EN] &
                    (disp_col == cur_x_reg) &
                    (disp_row == cur_y_reg);
   assign att_hit = disp_valid & disp_attr[crtac_pkg::ATTR_CURSOR];

   crtac_cursor_shape u_abs_shape (
      .shape      (ctrl_reg[crtac_pkg::CTL_ABS_SHAPE +: 2]),
      .hit        (abs_hit),
      .scan_line  (scan_line),
      .start_line (cursor_start_line_start_reg),
      .end_line   (cursor_start_line_end_reg),
      .cur        (a_cur),
      .rev        (a_rev),
      .ul         (a_ul)
   );

   crtac_cursor_shape u_att_shape (
      .shape      (ctrl_reg[crtac_pkg::CTL_ATT_SHAPE +: 2]),
      .hit        (att_hit),
      .scan_line  (scan_line),
      .start_line (cursor_start_line_start_reg),
      .end_line   (cursor_start_line_end_reg),
      .cur        (t_cur),
      .rev        (t_rev),
      .ul         (t_ul)
   );

   // ****************************************************************
   // Attribute port
   // ****************************************************************
   // Character attribute with cursors merged into reverse and underline.
   always_comb begin
      ap_now = disp_valid ? disp_attr[10:0] : 11'h000;
      ap_now[crtac_pkg::AP_REVERSE] = ap_now[crtac_pkg::AP_REVERSE] ^
                                      (a_rev | t_rev);
      ap_now[crtac_pkg::AP_UNDERLN] = ap_now[crtac_pkg::AP_UNDERLN] |
                                      a_ul | t_ul;
   end

   // Output stage: row attribute in its blanking window, zero in the rest of blanking, else skewed character data.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ap_d1_reg     <= 11'h000;
         attr_port_pin <= 11'h000;
         cursor_pin    <= 1'b0;
      end else begin
         ap_d1_reg  <= ap_now;
         cursor_pin <= a_cur | t_cur;
         if (row_on_next) begin
            attr_port_pin <= {row_attr_reg[9:5], 1'b0,
                              row_attr_reg[4:0]};
         end else if (blank) begin
            attr_port_pin <= 11'h000;
         end else begin
            attr_port_pin <= skew ? ap_d1_reg : ap_now;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_ignore_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == crtac_pkg::ST_LOAD && take && ld_has_attr &&
      ld_attr[crtac_pkg::ATTR_IGNORE] && !show_hidden |=> !buf_we)
      else $error("Ignored character was loaded.");
   a_default_use: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == crtac_pkg::ST_LOAD && take && !ld_has_attr && !skip &&
      ptr_reg < cap |=> buf_we && buf_attr == $past(default_reg))
      else $error("Default attribute not applied.");
   a_latch_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == crtac_pkg::ST_LOAD && take && ld_has_attr &&
      ld_attr[crtac_pkg::ATTR_LATCH] |=> default_reg == $past(ld_attr))
      else $error("Latched attribute did not reload default.");
   a_ignore_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ignore_reg && !show_hidden && take && !ld_has_attr |=> !buf_we)
      else $error("Character loaded while ignore latched.");
   a_row_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rrb_valid |=> $stable(row_attr_reg))
      else $error("Row attribute changed without a block.");
   a_row_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(row_on_reg) |-> hb_cnt_reg == 8'h07 + {7'h00, skew})
      else $error("Row attribute started at wrong clock.");
   a_pin5_row: assert property (@(posedge clk_sys) disable iff (!rst_n)
      row_on_reg |-> !attr_port_pin[crtac_pkg::AP_REVERSE])
      else $error("Pin 5 driven by row attribute.");
   a_abs_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ctrl_reg[crtac_pkg::CTL_ABS_EN] && !att_hit |=> !cursor_pin)
      else $error("Absolute cursor shown while disabled.");
   a_fill_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == crtac_pkg::ST_FILL && !row_start &&
      ptr_reg == cap - 8'h01 |=> state_reg == crtac_pkg::ST_DONE)
      else $error("Fill overran row buffer capacity.");
   a_fill_noattr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == crtac_pkg::ST_FILL && !row_start &&
      !ctrl_reg[crtac_pkg::CTL_FILL_ATTR] |=>
      buf_attr == $past(default_reg))
      else $error("Fill invoked an attribute while disabled.");

endmodule : crtac_top
`default_nettype wire

/* tb/crtac_latch_model.sv */
// Downstream latch model: captures the row attribute at sync fall.
// Assumes hsync is driven by the bench on the character clock.
`timescale 1ns/1ps
`default_nettype none
module crtac_latch_model (
   input  wire logic        clk_sys,
   input  wire logic        hsync,
   input  wire logic [10:0] attr_port_pin,
   output logic      [10:0] row_cap
);
   logic hs_reg = 1'b1;
   // Latch the attribute port on the falling sync edge.
   always_ff @(posedge clk_sys) begin
      hs_reg <= hsync;
      if (hs_reg && !hsync) row_cap <= attr_port_pin;
   end
endmodule : crtac_latch_model
`default_nettype wire

/* tb/tb_crtac_top.sv */
// Self-checking bench for the attribute, cursor and fill logic.
// Assumes crtac_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_crtac_top;
   logic clk_sys = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, row_start = 1'b0, ld_valid = 1'b0, ld_has_attr = 1'b0;
   logic seg_last = 1'b0, rrb_valid = 1'b0, blank = 1'b0, vretrace = 1'b0;
   logic scroll_active = 1'b0, relink = 1'b0, disp_valid = 1'b0, hsync = 1'b1;
   logic [3:0] wb_sel_i = 4'hF;
   logic [7:0] wb_adr_i = 8'h00, ld_char = 8'h41, disp_col = 8'h00, buf_addr, buf_char;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] ld_attr = 16'h0, fill_attr = 16'h2040, disp_attr = 16'h0, buf_attr;
   logic [9:0] rrb_row_attr = 10'h2A5;
   logic [4:0] rrb_cursor_start_line_start = 5'h02, rrb_cursor_start_line_end = 5'h04, scan_line = 5'h00;
   logic [6:0] disp_row = 7'h01;
   logic wb_ack_o, ld_ready, buf_we, cursor_pin;
   logic [10:0] attr_port_pin, row_cap;
   int fail_count = 0, n_compared = 0, k, n, i;
   // Load rows: has attribute, attribute, write expected, attribute expected.
   localparam logic [33:0] LT [11] = '{
      {1'b0, 16'h0000, 1'b1, 16'h0000}, {1'b1, 16'h8001, 1'b1, 16'h8001},
      {1'b0, 16'h0000, 1'b1, 16'h8001}, {1'b1, 16'h0004, 1'b1, 16'h0004},
      {1'b0, 16'h0000, 1'b1, 16'h8001}, {1'b1, 16'h2002, 1'b0, 16'h0000},
      {1'b1, 16'hA000, 1'b0, 16'h0000}, {1'b0, 16'h0000, 1'b0, 16'h0000},
      {1'b1, 16'h0010, 1'b0, 16'h0000}, {1'b1, 16'h8020, 1'b1, 16'h8020},
      {1'b0, 16'h0000, 1'b1, 16'h8020}};
   crtac_top i_crtac_top (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .row_start,
      .ld_valid, .ld_char, .ld_has_attr, .ld_attr, .ld_ready, .seg_last,
      .fill_attr, .buf_we, .buf_addr, .buf_char, .buf_attr, .rrb_valid,
      .rrb_row_attr, .rrb_cursor_start_line_start, .rrb_cursor_start_line_end, .blank, .vretrace,
      .scroll_active, .relink, .disp_valid, .disp_attr, .disp_col, .disp_row,
      .scan_line, .attr_port_pin, .cursor_pin);
   crtac_latch_model i_crtac_latch_model (.clk_sys, .hsync, .attr_port_pin,
      .row_cap);
   // Character clock of 100 MHz.
   always #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // One classic Wishbone cycle; the request holds until ack is sampled.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      k = 0;
      do begin @(posedge clk_sys); k++; end while (wb_ack_o !== 1'b1 && k < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (wb_ack_o !== 1'b1) begin fail_count++; give_verdict(); end
   endtask : wb
   task automatic pulse_row;
      @(posedge clk_sys); row_start <= 1'b1;
      @(posedge clk_sys); row_start <= 1'b0;
   endtask : pulse_row
   // Offer one character and check the row buffer write that follows.
   task automatic ld(input logic [33:0] r, inout int p);
      @(posedge clk_sys); {ld_has_attr, ld_attr} <= r[33:17]; ld_valid <= 1'b1;
      @(posedge clk_sys); ld_valid <= 1'b0;
      #1 chk({ld_ready, buf_we}, {1'b1, r[16]});
      if (r[16]) begin chk(buf_attr, r[15:0]); chk(buf_addr, p); p++; end
   endtask : ld
   task automatic cur(input logic [7:0] c, input logic [15:0] a,
                      input logic [4:0] s, input logic [11:0] e);
      @(posedge clk_sys);
      {disp_valid, disp_col, disp_attr, scan_line} <= {1'b1, c, a, s};
      @(posedge clk_sys); disp_valid <= 1'b0;
      #1 chk({cursor_pin, attr_port_pin}, e);
   endtask : cur
   // Main sequence.
   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0020_0000);
      wb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0);
      wb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
      $display("reset and registers done");
      wb(1'b1, 8'h00, 32'h0020_0006);
      pulse_row(); n = 0;
      for (i = 0; i < 11; i++) ld(LT[i], n);
      @(posedge clk_sys); seg_last <= 1'b1;
      @(posedge clk_sys); seg_last <= 1'b0; n = 0;
      for (i = 0; i < 120; i++) begin
         @(posedge clk_sys); #1;
         if (buf_we === 1'b1) begin
            if (n == 0) chk({buf_char, buf_attr}, 24'h20_0040);
            n++; k = buf_addr;
         end
      end
      chk(n, 89); chk(k, 95);
      wb(1'b1, 8'h00, 32'h0020_0001);
      pulse_row(); n = 0;
      ld({1'b1, 16'h2002, 1'b1, 16'h2002}, n);
      @(posedge clk_sys); seg_last <= 1'b1;
      @(posedge clk_sys); seg_last <= 1'b0;
      repeat (133) @(posedge clk_sys);
      chk({ld_ready, buf_addr, buf_attr}, 25'h083_8020);
      $display("load and fill done");
      @(posedge clk_sys); rrb_valid <= 1'b1;
      @(posedge clk_sys); rrb_valid <= 1'b0; blank <= 1'b1;
      for (n = 1; n < 32; n++) begin
         @(posedge clk_sys); if (n == 15) hsync <= 1'b0;
         #1 chk(attr_port_pin, (n >= 7 && n <= 30) ? 11'h545 : 11'h000);
      end
      @(posedge clk_sys); blank <= 1'b0; hsync <= 1'b1;
      chk(row_cap, 11'h545);
      wb(1'b0, 8'h0C, 32'h0); chk({rd[27:18], rd[15:0]}, 26'h2A5_8020);
      $display("row attribute done");
      wb(1'b1, 8'h08, 32'h0001_0003); wb(1'b1, 8'h00, 32'h0020_0008);
      @(posedge clk_sys); vretrace <= 1'b1;
      @(posedge clk_sys); vretrace <= 1'b0;
      cur(8'h03, 16'h0000, 5'h00, 12'h800); cur(8'h04, 16'h0000, 5'h00, 12'h000);
      wb(1'b1, 8'h08, 32'h0001_0004);
      @(posedge clk_sys); {scroll_active, vretrace} <= 2'h3;
      @(posedge clk_sys); vretrace <= 1'b0;
      cur(8'h03, 16'h0000, 5'h00, 12'h800);
      @(posedge clk_sys); relink <= 1'b1;
      @(posedge clk_sys); relink <= 1'b0;
      cur(8'h04, 16'h0000, 5'h00, 12'h800);
      wb(1'b1, 8'h00, 32'h0020_0028); cur(8'h04, 16'h0000, 5'h03, 12'h020);
      wb(1'b1, 8'h00, 32'h0020_0048); cur(8'h05, 16'h4000, 5'h02, 12'h800);
      cur(8'h05, 16'h4000, 5'h05, 12'h000);
      wb(1'b1, 8'h00, 32'h0020_0088); cur(8'h05, 16'h4020, 5'h03, 12'h000);
      wb(1'b1, 8'h00, 32'h0020_00C0); cur(8'h05, 16'h4000, 5'h04, 12'h002);
      wb(1'b1, 8'h00, 32'h0020_0000);
      cur(8'h04, 16'h0000, 5'h00, 12'h000);
      $display("cursor done");
      give_verdict();
   end
endmodule : tb_crtac_top
`default_nettype wire
